// *** bridge_power_management.sv ***
// power management of a pc card bridge with a 1394 function: wake status,
// pci clock-run hold and restart, card clock stop, 16-bit float, suspend gating
// assumes all inputs synchronous to clk_i; open-drain pins as in/out/oe triples, the wake pin as an out/oe pair only

// Contract
// - wake status set on unmasked 1394 event
// - vendor id bit 26 mirrors ignore bit
// - five power states, wake via wake pin
// - pci clock-run on multifunction pin six
// - hold bit refuses pci clock stop
// - busy engines refuse pci clock stop
// - pending irq or running card clock refuses
// - card interrupts request pci clock restart
// - wake or status events request restart
// - card clock-run or bus request restarts
// - idle card gets its clock stopped
// - output-disable bit floats and resets card
// - auto power-down floats idle card, no reset
// - suspend blocks resets, gates pci clock
// - resets during suspend keep registers
// - suspend floats outputs after granted transaction
// - gpio, multifunction and ring stay active; here only ring does: no gpio, pin six gets no new drive while gated
// - parallel indications need no pci clock
module bridge_power_management #(
  parameter int unsigned              INT_N    = 16,         // 1394 interrupt events
  parameter logic [15:0]              VENDOR   = 16'h5A5A,   // arbitrary value
  parameter int unsigned              IDLE_CNT = bridge_pm_pkg::IDLE_CYC
) (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  // register port
  input  wire logic [7:0]             addr_i,
  input  wire logic [31:0]            wdata_i,
  input  wire logic                   we_i,
  input  wire logic                   re_i,
  output logic      [31:0]            rdata_o,
  // system resets and suspend, all active low
  input  wire logic                   pci_reset_input_n_i,
  input  wire logic                   global_reset_input_n_i,
  input  wire logic                   suspend_n_i,
  input  wire logic                   gnt_n_i,
  // bridge activity
  input  wire bridge_pm_pkg::busy_type    busy_i,
  input  wire bridge_pm_pkg::card_ev_type card_ev_i,
  input  wire logic                   card16_idle_i,
  input  wire logic [INT_N-1:0]       int_event_i,
  // multifunction_pin_six: pci clock-run, open drain, low = asserted
  input  wire logic                   multifunction_pin_six_i,
  output logic                        multifunction_pin_six_o,
  output logic                        multifunction_pin_six_oe_o,
  // card clock-run line, open drain, low = asserted
  input  wire logic                   cclkrun_i,
  output logic                        cclkrun_o,
  output logic                        cclkrun_oe_o,
  output logic                        cclk_en_o,
  // 16-bit card control
  output logic                        card_hiz_o,
  output logic                        card_reset_o,
  // suspend effects
  output logic                        pci_clk_en_o,
  output logic                        pci_float_o,
  output logic                        serial_irq_run_o,
  // wake pin, open drain, low = asserted
  output logic                        pme_o,
  output logic                        pme_oe_o,
  // interrupts and ring
  output logic                        irq_o,
  output logic                        ring_indicate_output_o
);

  // all state of the block
  typedef struct packed {
    bridge_pm_pkg::pstate_type pstate;   // 1394 power state
    bridge_pm_pkg::cstate_type cstate;   // card clock manager
    logic                      hold_pci_clock_bit;
    logic                      ri_en;
    logic                      wake_ignores_master_enable;
    logic                      card_output_disable_bit;
    logic                      auto_card_powerdown_bit;
    logic                      pme_en;
    logic                      pme_sts;
    logic [31:0]               int_mask;
    logic [3:0]                irq_sts;
    logic [3:0]                irq_en;
    logic [31:0]               rdata;
    logic [7:0]                keep_cnt; // clock-run drive length
    logic [15:0]               idle_cnt; // card idle time
    logic [7:0]                ask_cnt;  // card refusal window
    logic                      gate_on;  // internal pci clock gated
    logic                      hiz;
    logic                      creset;
  } state_type;

  localparam state_type RST_ST = '{
    pstate: bridge_pm_pkg::PS_D0U,
    cstate: bridge_pm_pkg::CC_RUN,
    default: '0
  };

  state_type st_ff;   // registered state
  state_type nxt_st;  // next state

  // decoded helpers
  logic suspended;    // suspend pin active
  logic soft_rst;     // reset that actually reaches the registers
  logic unmasked;     // 1394 event passes mask and master enable
  logic restart;      // reason to restart the pci clock
  logic keep;         // reason to refuse a pci clock stop
  logic card_act;     // cardbus card activity
  logic [3:0] ev;     // interrupt events this cycle

  // word-aligned field write helper
  function automatic logic wbit(input logic [31:0] d, input int unsigned p);
    wbit = d[p];
  endfunction : wbit

  // register read mux, unmapped offsets read zero
  function automatic logic [31:0] rd_mux(input state_type s, input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    if (a == bridge_pm_pkg::PWR_CTRL_OFS) begin
      r[bridge_pm_pkg::COD_BIT] = s.card_output_disable_bit;
    end else if (a == bridge_pm_pkg::GLB_CTRL_OFS) begin
      r[bridge_pm_pkg::APD_BIT] = s.auto_card_powerdown_bit;
    end else if (a == bridge_pm_pkg::OHCI_VID_OFS) begin
      r[bridge_pm_pkg::VID_W-1:0] = VENDOR;
      r[bridge_pm_pkg::VID_IGN_BIT] = s.wake_ignores_master_enable;
    end else if (a == bridge_pm_pkg::OHCI_MASK_OFS) begin
      r = s.int_mask;
    end else if (a == bridge_pm_pkg::SYS_CTRL_OFS) begin
      r[bridge_pm_pkg::HOLD_CLK_BIT] = s.hold_pci_clock_bit;
      r[bridge_pm_pkg::RI_EN_BIT] = s.ri_en;
    end else if (a == bridge_pm_pkg::PMCSR_OFS) begin
      r[1:0] = pcode(s.pstate);
      r[bridge_pm_pkg::PME_EN_BIT] = s.pme_en;
      r[bridge_pm_pkg::PME_STS_BIT] = s.pme_sts;
    end else if (a == bridge_pm_pkg::IRQ_STAT_OFS) begin
      r[3:0] = s.irq_sts;
    end else if (a == bridge_pm_pkg::IRQ_EN_OFS) begin
      r[3:0] = s.irq_en;
    end else if (a == bridge_pm_pkg::OHCI_MISC_OFS) begin
      r[bridge_pm_pkg::IGN_ME_BIT] = s.wake_ignores_master_enable;
    end
    rd_mux = r;
  endfunction : rd_mux

  // power state to its two-bit code; both D0 flavours read as D0
  function automatic logic [1:0] pcode(input bridge_pm_pkg::pstate_type p);
    case (p)
      bridge_pm_pkg::PS_D1: pcode = bridge_pm_pkg::PS_CODE_D1;
      bridge_pm_pkg::PS_D2: pcode = bridge_pm_pkg::PS_CODE_D2;
      bridge_pm_pkg::PS_D3: pcode = bridge_pm_pkg::PS_CODE_D3;
      default:              pcode = bridge_pm_pkg::PS_CODE_D0;
    endcase
  endfunction : pcode

  // decode of shared conditions
  always_comb begin
    suspended = ~suspend_n_i;
    // resets are blocked while suspended so context survives
    soft_rst  = ~suspended & (~pci_reset_input_n_i | ~global_reset_input_n_i);
    unmasked  = (|(int_event_i & st_ff.int_mask[INT_N-1:0])) &
                (st_ff.wake_ignores_master_enable |
                 st_ff.int_mask[bridge_pm_pkg::MASTER_EN_BIT]);
    card_act  = card_ev_i.creq | card_ev_i.cint | busy_i.cb_master;
    restart   = card_ev_i.ireq | card_ev_i.cint
              | card_ev_i.cardbus_wake_event | card_ev_i.stschg_ri
              | card_ev_i.creq | (st_ff.cstate == bridge_pm_pkg::CC_STOP & ~cclkrun_i);
    keep      = st_ff.hold_pci_clock_bit
              | busy_i.res_mgr | busy_i.cb_master | busy_i.pci_master
              | irq_o | card_ev_i.ireq | card_ev_i.cint
              | (st_ff.cstate != bridge_pm_pkg::CC_STOP);
  end

  // next-state logic of the whole block
  always_comb begin
    nxt_st = st_ff;
    ev     = '0;
    // read data stands only in the cycle after the read strobe
    nxt_st.rdata = '0;

    // pci clock-run: central resource releases the line to ask for a stop
    // or while the clock is stopped; we pull it low to hold or restart
    if (st_ff.keep_cnt != '0) begin
      nxt_st.keep_cnt = st_ff.keep_cnt - 8'h01;
    end else if (multifunction_pin_six_i & ~st_ff.gate_on & (keep | restart)) begin
      nxt_st.keep_cnt = 8'(bridge_pm_pkg::KEEP_CYC);
      ev[bridge_pm_pkg::EV_RESTART] = restart;
      ev[bridge_pm_pkg::EV_REFUSE]  = keep;
    end

    // card clock manager: stop the card clock after idle time
    case (st_ff.cstate)
      bridge_pm_pkg::CC_RUN: begin
        if (card_act) begin
          nxt_st.idle_cnt = '0;
        end else if (st_ff.idle_cnt >= 16'(IDLE_CNT - 1)) begin
          nxt_st.cstate  = bridge_pm_pkg::CC_ASK;
          nxt_st.ask_cnt = '0;
        end else begin
          nxt_st.idle_cnt = st_ff.idle_cnt + 16'h0001;
        end
      end
      bridge_pm_pkg::CC_ASK: begin
        // card holds the line low to refuse the stop
        if (~cclkrun_i | card_act) begin
          nxt_st.cstate   = bridge_pm_pkg::CC_RUN;
          nxt_st.idle_cnt = '0;
        end else if (st_ff.ask_cnt >= 8'(bridge_pm_pkg::ASK_CYC - 1)) begin
          nxt_st.cstate = bridge_pm_pkg::CC_STOP;
          ev[bridge_pm_pkg::EV_CCLK_STOP] = 1'b1;
        end else begin
          nxt_st.ask_cnt = st_ff.ask_cnt + 8'h01;
        end
      end
      bridge_pm_pkg::CC_STOP: begin
        // card asks for its clock back, or we need the bus
        if (~cclkrun_i | card_act) begin
          nxt_st.cstate   = bridge_pm_pkg::CC_RUN;
          nxt_st.idle_cnt = '0;
        end
      end
      default: begin
        nxt_st.cstate = bridge_pm_pkg::CC_RUN;
      end
    endcase

    // 16-bit card float and reset, registered
    nxt_st.creset = st_ff.card_output_disable_bit;
    nxt_st.hiz    = st_ff.card_output_disable_bit |
                    (st_ff.auto_card_powerdown_bit & card16_idle_i);

    // suspend gating waits for a granted transaction to finish
    if (~suspended) begin
      nxt_st.gate_on = 1'b0;
    end else if (gnt_n_i) begin
      nxt_st.gate_on = 1'b1;
    end

    // wake status: not generated before configuration
    if (st_ff.pstate != bridge_pm_pkg::PS_D0U & unmasked & ~st_ff.pme_sts) begin
      ev[bridge_pm_pkg::EV_PME] = 1'b1;
    end

    // register writes; ignored while the internal clock is gated
    if (we_i & ~st_ff.gate_on) begin
      if (addr_i == bridge_pm_pkg::PWR_CTRL_OFS) begin
        nxt_st.card_output_disable_bit = wbit(wdata_i, bridge_pm_pkg::COD_BIT);
      end else if (addr_i == bridge_pm_pkg::GLB_CTRL_OFS) begin
        nxt_st.auto_card_powerdown_bit = wbit(wdata_i, bridge_pm_pkg::APD_BIT);
      end else if (addr_i == bridge_pm_pkg::OHCI_MASK_OFS) begin
        nxt_st.int_mask = wdata_i;
      end else if (addr_i == bridge_pm_pkg::SYS_CTRL_OFS) begin
        nxt_st.hold_pci_clock_bit = wbit(wdata_i, bridge_pm_pkg::HOLD_CLK_BIT);
        nxt_st.ri_en = wbit(wdata_i, bridge_pm_pkg::RI_EN_BIT);
      end else if (addr_i == bridge_pm_pkg::PMCSR_OFS) begin
        nxt_st.pme_en = wbit(wdata_i, bridge_pm_pkg::PME_EN_BIT);
        // write one clears wake status
        if (wbit(wdata_i, bridge_pm_pkg::PME_STS_BIT)) begin
          nxt_st.pme_sts = 1'b0;
        end
        // first state write configures the function
        case (wdata_i[1:0])
          bridge_pm_pkg::PS_CODE_D1: nxt_st.pstate = bridge_pm_pkg::PS_D1;
          bridge_pm_pkg::PS_CODE_D2: nxt_st.pstate = bridge_pm_pkg::PS_D2;
          bridge_pm_pkg::PS_CODE_D3: nxt_st.pstate = bridge_pm_pkg::PS_D3;
          default:                   nxt_st.pstate = bridge_pm_pkg::PS_D0A;
        endcase
      end else if (addr_i == bridge_pm_pkg::IRQ_CLR_OFS) begin
        nxt_st.irq_sts = st_ff.irq_sts & ~wdata_i[3:0];
      end else if (addr_i == bridge_pm_pkg::IRQ_EN_OFS) begin
        nxt_st.irq_en = wdata_i[3:0];
      end else if (addr_i == bridge_pm_pkg::OHCI_MISC_OFS) begin
        nxt_st.wake_ignores_master_enable = wbit(wdata_i, bridge_pm_pkg::IGN_ME_BIT);
      end
    end

    // events set after clears so a set in the clear cycle wins
    nxt_st.irq_sts = nxt_st.irq_sts | ev;
    if (st_ff.pstate != bridge_pm_pkg::PS_D0U & unmasked) begin
      nxt_st.pme_sts = 1'b1;
    end

    // register read, answered in the next cycle
    if (re_i & ~st_ff.gate_on) begin
      nxt_st.rdata = rd_mux(st_ff, addr_i);
    end

    // reset from the pins: wake context survives pci reset while enabled
    if (soft_rst) begin
      nxt_st = RST_ST;
      nxt_st.gate_on = st_ff.gate_on;
      if (pci_reset_input_n_i | ~global_reset_input_n_i) begin
        nxt_st.pme_en  = 1'b0;
        nxt_st.pme_sts = 1'b0;
      end else if (st_ff.pme_en) begin
        nxt_st.pme_en  = st_ff.pme_en;
        nxt_st.pme_sts = st_ff.pme_sts;
      end
    end
  end

  // single state register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // output drive
  always_comb begin
    rdata_o                    = st_ff.rdata;
    multifunction_pin_six_o    = 1'b0;
    multifunction_pin_six_oe_o = st_ff.keep_cnt != '0;
    cclkrun_o                  = 1'b0;
    // line held asserted while the card clock runs, released to ask
    cclkrun_oe_o               = st_ff.cstate == bridge_pm_pkg::CC_RUN;
    cclk_en_o                  = st_ff.cstate != bridge_pm_pkg::CC_STOP;
    card_hiz_o                 = st_ff.hiz;
    card_reset_o               = st_ff.creset;
    pci_clk_en_o               = ~st_ff.gate_on;
    pci_float_o                = st_ff.gate_on;
    // the serial interrupt engine has no clock of its own
    serial_irq_run_o           = ~st_ff.gate_on;
    pme_o                      = 1'b0;
    pme_oe_o                   = st_ff.pme_sts & st_ff.pme_en;
    irq_o                      = |(st_ff.irq_sts & st_ff.irq_en);
    // parallel ring path has no flop so it works with the clock gated
    ring_indicate_output_o     = st_ff.ri_en & (card_ev_i.stschg_ri | card_ev_i.cardbus_wake_event);
  end

endmodule : bridge_power_management

// *** bridge_pm_pkg.sv ***
// constants, field positions and carrier types of the bridge power-management block
// assumes one 20 MHz clock and a plain register port with byte offsets in 8 bits
package bridge_pm_pkg;

  // register port widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] PWR_CTRL_OFS  = 8'h02;
  localparam logic [7:0] GLB_CTRL_OFS  = 8'h1E;
  localparam logic [7:0] OHCI_VID_OFS  = 8'h40;
  localparam logic [7:0] OHCI_MASK_OFS = 8'h48;
  localparam logic [7:0] SYS_CTRL_OFS  = 8'h80;
  localparam logic [7:0] PMCSR_OFS     = 8'hA4;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'hC0;
  localparam logic [7:0] IRQ_CLR_OFS   = 8'hC4;
  localparam logic [7:0] IRQ_EN_OFS    = 8'hC8;
  localparam logic [7:0] OHCI_MISC_OFS = 8'hF0;

  // field positions
  localparam int unsigned HOLD_CLK_BIT  = 1;
  localparam int unsigned RI_EN_BIT     = 7;
  localparam int unsigned COD_BIT       = 7;
  localparam int unsigned APD_BIT       = 0;
  localparam int unsigned IGN_ME_BIT    = 10;
  localparam int unsigned VID_IGN_BIT   = 26;
  localparam int unsigned MASTER_EN_BIT = 31;
  localparam int unsigned PME_EN_BIT    = 8;
  localparam int unsigned PME_STS_BIT   = 15;
  localparam int unsigned VID_W         = 16;

  // power-state codes of the two-bit state field
  localparam logic [1:0] PS_CODE_D0 = 2'h0;
  localparam logic [1:0] PS_CODE_D1 = 2'h1;
  localparam logic [1:0] PS_CODE_D2 = 2'h2;
  localparam logic [1:0] PS_CODE_D3 = 2'h3;

  // interrupt status bit positions
  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned EV_PME       = 0;
  localparam int unsigned EV_RESTART   = 1;
  localparam int unsigned EV_REFUSE    = 2;
  localparam int unsigned EV_CCLK_STOP = 3;

  // timing
  localparam longint unsigned CLK_HZ       = 64'h0000_0000_0131_2D00;
  localparam longint unsigned KEEP_NS      = 64'h0000_0000_0000_00C8;
  localparam longint unsigned CARD_IDLE_NS = 64'h0000_0000_0000_2710;
  localparam longint unsigned CARD_ASK_NS  = 64'h0000_0000_0000_0190;
  localparam longint unsigned NS_PER_S     = 64'h0000_0000_3B9A_CA00;
  // least times, rounded up to whole cycles
  localparam int unsigned KEEP_CYC = int'((KEEP_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int unsigned IDLE_CYC = int'((CARD_IDLE_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int unsigned ASK_CYC  = int'((CARD_ASK_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);

  // 1394 function power states, one-hot
  typedef enum logic [4:0] {
    PS_D0U = 5'h01,
    PS_D0A = 5'h02,
    PS_D1  = 5'h04,
    PS_D2  = 5'h08,
    PS_D3  = 5'h10
  } pstate_type;

  // card clock manager states, one-hot
  typedef enum logic [2:0] {
    CC_RUN  = 3'h1,
    CC_ASK  = 3'h2,
    CC_STOP = 3'h4
  } cstate_type;

  // socket events seen at the card pins
  typedef struct packed {
    logic ireq;       // 16-bit card interrupt request
    logic cint;       // cardbus card interrupt
    logic cardbus_wake_event;     // cardbus_wake_event on status change pin
    logic stschg_ri;  // 16-bit status change or ring
    logic creq;       // cardbus bus request
  } card_ev_type;

  // busy indications of the bridge engines
  typedef struct packed {
    logic res_mgr;    // 16-bit card resource manager
    logic cb_master;  // cardbus master state machine
    logic pci_master; // pci master holding posted data
  } busy_type;

endpackage : bridge_pm_pkg

// *** bridge_pm_props.sv ***
// port-level checker of the bridge power-management block
// assumes one clock domain; bound onto every bridge_power_management instance
module bridge_pm_props (
  // clock and reset
  input wire logic                       clk_i,
  input wire logic                       rstn_i,
  // watched inputs
  input wire logic                       suspend_n_i,
  input wire logic                       gnt_n_i,
  input wire bridge_pm_pkg::busy_type    busy_i,
  input wire bridge_pm_pkg::card_ev_type card_ev_i,
  input wire logic                       card16_idle_i,
  input wire logic                       multifunction_pin_six_i,
  // watched outputs
  input wire logic                       multifunction_pin_six_oe_o,
  input wire logic                       cclkrun_oe_o,
  input wire logic                       cclk_en_o,
  input wire logic                       card_hiz_o,
  input wire logic                       card_reset_o,
  input wire logic                       pci_clk_en_o,
  input wire logic                       pci_float_o,
  input wire logic                       serial_irq_run_o,
  input wire logic                       ring_indicate_output_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // host has released the line and the bridge may answer; suspend excluded as gating may land
  logic take;
  assign take = multifunction_pin_six_i && !multifunction_pin_six_oe_o && !pci_float_o && suspend_n_i;

  a_irq_restart: assert property (take && (card_ev_i.ireq || card_ev_i.cint) |=> multifunction_pin_six_oe_o)
    else $error("card interrupt did not restart pci clock");
  a_event_restart: assert property (take && (card_ev_i.cardbus_wake_event || card_ev_i.stschg_ri || card_ev_i.creq)
    |=> multifunction_pin_six_oe_o) else $error("socket event did not restart pci clock");
  a_busy_hold: assert property (take && (|busy_i) |=> multifunction_pin_six_oe_o [*4])
    else $error("busy engine did not hold pci clock");
  a_drive_span: assert property ($rose(multifunction_pin_six_oe_o) |-> multifunction_pin_six_oe_o [*4])
    else $error("clock-run drive shorter than four cycles");
  a_card_reset: assert property (card_reset_o |-> card_hiz_o)
    else $error("card reset without floated interface");
  a_auto_float: assert property (card_hiz_o && !card_reset_o |-> $past(card16_idle_i))
    else $error("card floated while busy");
  a_suspend_gate: assert property (!suspend_n_i && gnt_n_i |=> pci_float_o && !pci_clk_en_o)
    else $error("suspend did not gate pci clock");
  a_grant_wait: assert property (!suspend_n_i && !gnt_n_i && !pci_float_o |=> !pci_float_o)
    else $error("gated during granted transaction");
  a_sirq_clock: assert property (!pci_clk_en_o |-> !serial_irq_run_o)
    else $error("serial irq runs without pci clock");
  a_ring_cause: assert property (ring_indicate_output_o |-> card_ev_i.stschg_ri || card_ev_i.cardbus_wake_event)
    else $error("ring output without cause");
  a_card_ask: assert property ($fell(cclk_en_o) |-> $past(cclkrun_oe_o) == 1'b0)
    else $error("card clock stopped without release phase");
endmodule : bridge_pm_props

bind bridge_power_management bridge_pm_props u_props (.clk_i, .rstn_i, .suspend_n_i, .gnt_n_i, .busy_i,
  .card_ev_i, .card16_idle_i, .multifunction_pin_six_i, .multifunction_pin_six_oe_o, .cclkrun_oe_o,
  .cclk_en_o, .card_hiz_o, .card_reset_o, .pci_clk_en_o, .pci_float_o, .serial_irq_run_o,
  .ring_indicate_output_o);

// *** clock_resource_model.sv ***
// model of the host chipset's central clock resource and pci arbiter
// assumes the bridge only pulls the clock-run line low; a pull-up gives high otherwise
module clock_resource_model (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic stop_req_i,  // bench asks the host to try a clock stop
  input  wire logic dev_oe_i,    // bridge pulls the line low
  input  wire logic grant_req_i, // bench wants the bridge granted
  input  wire logic suspend_n_i,
  output logic      pin_o,
  output logic      gnt_n_o,
  output logic      stopped_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       host_oe_ff; // host holds the line low while the clock must run
  logic [1:0] wait_ff;    // cycles the released line has stayed high
  // wired-or of both pull-downs over the pull-up
  assign pin_o = !(host_oe_ff || dev_oe_i);
  // release, watch for the bridge's hold, then stop
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      host_oe_ff <= 1'b1;
      wait_ff    <= 2'h0;
      stopped_o  <= 1'b0;
      gnt_n_o    <= 1'b1;
    end else begin
      gnt_n_o <= !(grant_req_i && suspend_n_i);
      if (!stop_req_i) begin
        host_oe_ff <= 1'b1;
        wait_ff    <= 2'h0;
        stopped_o  <= 1'b0;
      end else if (host_oe_ff) begin
        host_oe_ff <= 1'b0;
        wait_ff    <= 2'h0;
      end else if (!pin_o) begin
        // bridge refused or asked for restart: clock keeps running
        wait_ff   <= 2'h0;
        stopped_o <= 1'b0;
      end else if (wait_ff == 2'h3) begin
        stopped_o <= 1'b1;
      end else begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
endmodule : clock_resource_model

// *** bridge_power_management_test.sv ***
// testbench of the bridge power-management block with a clock resource model
// assumes a 20 MHz clock and a short card idle count
module bridge_power_management_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rstn_i = 0, we_i = 0, re_i = 0, pci_reset_input_n = 1, global_reset_input_n = 1, suspend_n_i = 1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  bridge_pm_pkg::busy_type busy_i = '0;
  bridge_pm_pkg::card_ev_type card_ev_i = '0;
  logic idle = 0, stop_req = 0, grant_req = 0, card_drive = 0;
  logic [15:0] int_event_i = 16'h0;
  logic pin_w, pin_oe, cclk_oe, cclk_en, hiz, crst, pclk_en, pfl, sirq, pme_oe, irq, ring, gnt_n, stopped;
  int failures = 0, checks = 0, cyc = 0;
  // card side of the open-drain card clock-run line
  wire cclkrun_w = !(cclk_oe || card_drive);
  always #25 clk_i = ~clk_i;

  bridge_power_management #(.IDLE_CNT(8)) dut (.clk_i, .rstn_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
    .pci_reset_input_n_i(pci_reset_input_n), .global_reset_input_n_i(global_reset_input_n), .suspend_n_i, .gnt_n_i(gnt_n), .busy_i,
    .card_ev_i, .card16_idle_i(idle), .int_event_i, .multifunction_pin_six_i(pin_w),
    .multifunction_pin_six_o(), .multifunction_pin_six_oe_o(pin_oe), .cclkrun_i(cclkrun_w), .cclkrun_o(),
    .cclkrun_oe_o(cclk_oe), .cclk_en_o(cclk_en), .card_hiz_o(hiz), .card_reset_o(crst),
    .pci_clk_en_o(pclk_en), .pci_float_o(pfl), .serial_irq_run_o(sirq), .pme_o(), .pme_oe_o(pme_oe),
    .irq_o(irq), .ring_indicate_output_o(ring));
  clock_resource_model host (.clk_i, .rstn_i, .stop_req_i(stop_req), .dev_oe_i(pin_oe),
    .grant_req_i(grant_req), .suspend_n_i, .pin_o(pin_w), .gnt_n_o(gnt_n), .stopped_o(stopped));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cy
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i) begin we_i <= 1; addr_i <= a; wdata_i <= d; end
    @(posedge clk_i) we_i <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i) begin re_i <= 1; addr_i <= a; end
    @(posedge clk_i) re_i <= 0;
    #1 chk("rdata", exp, rdata_o);
  endtask : rd
  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // a hang counts as a mismatch
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    cy(6);
    @(posedge clk_i) rstn_i <= 1;
    @(posedge clk_i) stop_req <= 1;
    cy(6); chk("stopped", 0, stopped);
    wr(8'hF0, 32'h400); rd(8'h40, 32'h0400_5A5A);
    wr(8'hF0, 32'h0); rd(8'h40, 32'h0000_5A5A);
    wr(8'h10, 32'hFFFF_FFFF); rd(8'h10, 32'h0);
    cy(30); chk("cclk_en", 0, cclk_en);
    chk("stopped", 1, stopped);
    rd(8'hC0, 32'hC); wr(8'hC4, 32'hC); rd(8'hC0, 32'h0);
    // restart causes, the last one is the card pulling its clock-run line
    for (int k = 0; k < 6; k++) begin
      cy(40); chk("stopped", 1, stopped);
      @(posedge clk_i) if (k < 5) card_ev_i <= 5'(1 << k); else card_drive <= 1;
      cy(3); chk("restart", 0, stopped);
      @(posedge clk_i) begin card_ev_i <= '0; card_drive <= 0; end
    end
    // pending interrupt holds the clock; masking releases it
    cy(40);
    @(posedge clk_i) stop_req <= 0;
    wr(8'hC8, 32'h2); cy(1); chk("irq", 1, irq);
    @(posedge clk_i) stop_req <= 1;
    cy(12); chk("stopped", 0, stopped);
    wr(8'hC8, 32'h0); cy(1); chk("irq", 0, irq);
    wr(8'hC4, 32'hF); cy(10); chk("stopped", 1, stopped);
    // hold bit and each busy engine refuse the stop
    for (int k = 0; k < 4; k++) begin
      cy(30);
      @(posedge clk_i) stop_req <= 0;
      if (k == 0) wr(8'h80, 32'h2); else @(posedge clk_i) busy_i <= 3'(4 >> (k - 1));
      @(posedge clk_i) stop_req <= 1;
      cy(12); chk("refuse", 0, stopped);
      wr(8'h80, 32'h0);
      @(posedge clk_i) busy_i <= '0;
    end
    // 16-bit card float with and without reset
    wr(8'h02, 32'h80); cy(1); chk("hiz", 1, hiz); chk("crst", 1, crst);
    wr(8'h02, 32'h0); wr(8'h1E, 32'h1);
    @(posedge clk_i) idle <= 1;
    cy(2); chk("hiz", 1, hiz); chk("crst", 0, crst);
    @(posedge clk_i) idle <= 0;
    cy(2); chk("hiz", 0, hiz);
    // wake status in each coded state, with and without the master enable
    wr(8'h48, 32'h1);
    for (int st = 0; st < 4; st++) begin
      wr(8'hF0, 32'h0); wr(8'hA4, 32'h100 | st);
      @(posedge clk_i) int_event_i <= 16'h1;
      cy(2); chk("pme", 0, pme_oe);
      wr(8'hF0, 32'h400); cy(1); chk("pme", 1, pme_oe);
      rd(8'hA4, 32'h8100 | st);
      @(posedge clk_i) int_event_i <= 16'h0;
      wr(8'hA4, 32'h8100 | st); rd(8'hA4, 32'h100 | st);
    end
    wr(8'hF0, 32'h0); wr(8'h48, 32'h8000_0001);
    @(posedge clk_i) int_event_i <= 16'h1;
    cy(2); chk("pme", 1, pme_oe);
    // suspend during a granted transaction, resets blocked, ring still passes
    wr(8'h80, 32'h82);
    @(posedge clk_i) grant_req <= 1;
    @(posedge clk_i) suspend_n_i <= 0;
    cy(1); chk("float", 0, pfl);
    cy(2); chk("float", 1, pfl); chk("pclk", 0, pclk_en); chk("sirq", 0, sirq);
    @(posedge clk_i) begin pci_reset_input_n <= 0; global_reset_input_n <= 0; card_ev_i.stschg_ri <= 1; end
    cy(2); chk("ring", 1, ring);
    @(posedge clk_i) begin pci_reset_input_n <= 1; global_reset_input_n <= 1; card_ev_i <= '0; end
    @(posedge clk_i) begin suspend_n_i <= 1; grant_req <= 0; end
    cy(2); chk("pclk", 1, pclk_en);
    rd(8'h80, 32'h82);
    @(posedge clk_i) pci_reset_input_n <= 0;
    @(posedge clk_i) pci_reset_input_n <= 1;
    rd(8'h80, 32'h0);
    stop_test();
  end
endmodule : bridge_power_management_test
